//--- core/rdc_pkg.sv
// Contract
// - Two select pins choose 10/12/15/20 kHz; code uses the Wishbone control register ctrl_q instead
// - Select inputs default high, giving 10 kHz
// - Synthetic reference from larger signal's zero crossing
// - Reset zeroes position, drives both flags low
// - Sample strobe after settle releases flags, data
// - Encoder outputs keep updating during settle
// - Charge pump 204.8 kHz, 50% duty
// - First integrator accumulates error into velocity
// - Compensator zero 4095/4096, pole 4085/4096
// - Second integrator accumulates velocity into position
// - Loop updated once per 4.096 MHz tick
// - Sin/cos feedback lookup has unity gain
// - Velocity scales with clock, no correction
// - Tracking-loss flag at 5 degree error
// - Serial: one bit per falling clock edge
// - Word: data 15..4, select, flags, odd parity
// - Sample fall copies integrators to holding registers
// - Read fall loads shift register, starts shifting
package rdc_pkg;
   localparam int unsigned CLK_HZ = 200000000;
   localparam int unsigned TICK_HZ = 4096000;
   localparam logic [31:0] TICK_INC = 32'((64'(TICK_HZ) << 32) / 64'(CLK_HZ));
   localparam logic [3:0] CP_HALF_TICKS = 4'hA;
   // Excitation phase steps per tick, 16-bit phase word
   localparam logic [15:0] EXC_INC_10K = 16'h00A0;
   localparam logic [15:0] EXC_INC_12K = 16'h00C0;
   localparam logic [15:0] EXC_INC_15K = 16'h00F0;
   localparam logic [15:0] EXC_INC_20K = 16'h0140;
   localparam int ACC_W = 36;
   localparam int COEF_SHIFT = 12;
   localparam logic [ACC_W+3:0] POLE_DEFICIT = 40'h00_0000_000B;
   // Error magnitude of about sin(5 deg) at full-scale inputs
   localparam logic [25:0] LOT_ERR_TH = 26'h005_91D8;
   localparam logic [11:0] DOS_MIN_AMP = 12'h100;
   // Wishbone map, byte addresses
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_POS_HOLD = 8'h08;
   localparam logic [7:0] ADR_VEL_HOLD = 8'h0C;
   localparam logic [7:0] ADR_LIVE = 8'h10;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int SER_W = 16;
   typedef struct packed {
      logic sclk;
      logic rd_n;
      logic sample_n;
      logic pos_vel_select;
   } link_pins_t;
   typedef struct packed {
      logic [11:0] data;
      logic sel;
      logic degraded;
      logic lost;
      logic parity;
   } serial_word_t;
endpackage : rdc_pkg

//--- core/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '1;
         q_o <= '1;
      end else if (ce_i) begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : sync2
`default_nettype wire

//--- core/resolver_tracking_control.sv
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module resolver_tracking_control
   import rdc_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Digitised, filtered resolver signals
   input wire logic signed [11:0] sin_in_i,
   input wire logic signed [11:0] cos_in_i,
   // Host link pins
   input wire logic sclk_i,
   input wire logic rd_n_i,
   input wire logic sample_n_i,
   input wire logic pos_vel_select_i,
   // Serial data
   output logic serial_out_o,
   // Fault pins, low means fault
   output logic tracking_lost_flag_n_o,
   output logic degradation_pin_n_o,
   // Reference and supply helpers
   output logic excitation_out_o,
   output logic synth_ref_o,
   output logic charge_pump_out_o,
   // Encoder emulation
   output logic enc_a_o,
   output logic enc_b_o,
   output logic enc_nm_o,
   output logic enc_dir_o,
   // Live position word
   output logic [11:0] position_o
);

   // Link pins come from another domain
   link_pins_t pins_raw;
   link_pins_t pins;
   assign pins_raw = '{sclk: sclk_i, rd_n: rd_n_i, sample_n: sample_n_i,
                       pos_vel_select: pos_vel_select_i};

   sync2 #(
      .W(4)
   ) u_pin_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i(pins_raw),
      .q_o(pins)
   );

   // Internal 4.096 MHz tick by phase accumulation
   logic [31:0] tick_acc_q;
   logic [32:0] tick_sum;
   logic tick;
   assign tick_sum = {1'b0, tick_acc_q} + {1'b0, TICK_INC};
   assign tick = tick_sum[32] & ce_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_acc_q <= '0;
      end else if (ce_i) begin
         tick_acc_q <= tick_sum[31:0];
      end
   end

   // Wishbone slave
   logic [1:0] ctrl_q;
   logic wb_req;
   logic wb_wr_ctrl;
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_CTRL);

   // Charge pump: divide tick by twenty
   logic [3:0] cp_cnt_q;
   logic cp_wrap;
   assign cp_wrap = (cp_cnt_q == CP_HALF_TICKS - 4'h1);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cp_cnt_q <= '0;
         charge_pump_out_o <= 1'b0;
      end else if (tick) begin
         cp_cnt_q <= cp_wrap ? 4'h0 : cp_cnt_q + 4'h1;
         if (cp_wrap) begin
            charge_pump_out_o <= ~charge_pump_out_o;
         end
      end
   end

   // Excitation phase
   logic [15:0] exc_phase_q;
   logic [15:0] exc_inc;
   assign exc_inc = (ctrl_q == 2'b11) ? EXC_INC_10K :
                    (ctrl_q == 2'b10) ? EXC_INC_12K :
                    (ctrl_q == 2'b01) ? EXC_INC_15K : EXC_INC_20K;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         exc_phase_q <= '0;
      end else if (tick) begin
         exc_phase_q <= exc_phase_q + exc_inc;
      end
   end

   // Synthetic reference
   logic signed [12:0] sin_x;
   logic signed [12:0] cos_x;
   logic [11:0] sin_mag;
   logic [11:0] cos_mag;
   logic use_sin;
   logic sel_neg;
   logic sel_neg_q;
   logic zero_cross;
   logic [15:0] ref_off_q;
   logic [15:0] synth_phase;
   logic synth_ref;
   assign sin_x = 13'(sin_in_i);
   assign cos_x = 13'(cos_in_i);
   assign sin_mag = sin_x[12] ? 12'(-sin_x) : 12'(sin_x);
   assign cos_mag = cos_x[12] ? 12'(-cos_x) : 12'(cos_x);
   // track the larger signal for phase accuracy
   assign use_sin = (sin_mag >= cos_mag);
   assign sel_neg = use_sin ? sin_x[12] : cos_x[12];
   assign zero_cross = sel_neg_q & ~sel_neg;
   assign synth_phase = exc_phase_q - ref_off_q;
   assign synth_ref = ~synth_phase[15];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_neg_q <= 1'b0;
         ref_off_q <= '0;
      end else if (tick) begin
         sel_neg_q <= sel_neg;
         if (zero_cross) begin
            ref_off_q <= exc_phase_q;
         end
      end
   end

   // Demodulate with the synthetic reference
   logic signed [12:0] sin_dm;
   logic signed [12:0] cos_dm;
   assign sin_dm = synth_ref ? sin_x : -sin_x;
   assign cos_dm = synth_ref ? cos_x : -cos_x;

   // Parabolic sine, peak 2047 for unity gain
   function automatic logic signed [12:0] para_sin(input logic [11:0] p);
      logic [10:0] x;
      logic [21:0] m;
      logic [11:0] mag;
      x = p[10:0];
      m = 22'(x) * (22'h00_0800 - 22'(x));
      mag = (m[20:9] == 12'h800) ? 12'h7FF : m[20:9];
      para_sin = p[11] ? -13'(mag) : 13'(mag);
   endfunction : para_sin

   // Tracking loop state
   logic signed [ACC_W-1:0] vel_q;
   logic signed [ACC_W-1:0] comp_q;
   logic signed [ACC_W-1:0] pos_q;
   logic [11:0] angle;
   logic signed [12:0] sin_fb;
   logic signed [12:0] cos_fb;
   logic signed [25:0] err;
   logic signed [ACC_W-1:0] vel_d;
   logic signed [ACC_W+3:0] comp_x11;
   logic signed [ACC_W-1:0] comp_d;
   logic signed [ACC_W-1:0] pos_d;
   assign angle = pos_q[ACC_W-1 -: 12];
   assign sin_fb = para_sin(angle);
   assign cos_fb = para_sin(angle + 12'h400);
   assign err = 26'(sin_dm * cos_fb) - 26'(cos_dm * sin_fb);
   assign vel_d = vel_q + ACC_W'(err);
   // zero a = 1 - 1/4096, pole b = 1 - 11/4096
   assign comp_x11 = (ACC_W+4)'(comp_q) * $signed(POLE_DEFICIT);
   assign comp_d = vel_d - vel_q + (vel_q >>> COEF_SHIFT) + comp_q
                   - ACC_W'(comp_x11 >>> COEF_SHIFT);
   assign pos_d = pos_q + comp_d;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vel_q <= '0;
         comp_q <= '0;
         pos_q <= '0;
      end else if (tick) begin
         // one update per tick, no rescaling
         vel_q <= vel_d;
         comp_q <= comp_d;
         pos_q <= pos_d;
      end
   end

   // Fault detection
   logic [25:0] err_mag;
   logic lot_raw;
   logic dos_raw;
   logic flags_forced_q;
   logic signal_lost_state;
   assign err_mag = err[25] ? 26'(-err) : 26'(err);
   assign lot_raw = (err_mag >= LOT_ERR_TH);
   assign dos_raw = (sin_mag < DOS_MIN_AMP) & (cos_mag < DOS_MIN_AMP);
   assign signal_lost_state = flags_forced_q;

   // Link edges
   logic sample_n_q;
   logic rd_n_q;
   logic sclk_q;
   logic sample_fall;
   logic rd_fall;
   logic sclk_rise;
   assign sample_fall = sample_n_q & ~pins.sample_n;
   assign rd_fall = rd_n_q & ~pins.rd_n;
   assign sclk_rise = ~sclk_q & pins.sclk;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sample_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         sclk_q <= 1'b1;
      end else if (ce_i) begin
         sample_n_q <= pins.sample_n;
         rd_n_q <= pins.rd_n;
         sclk_q <= pins.sclk;
      end
   end

   // Holding registers and flag release
   logic [11:0] pos_hold_q;
   logic [11:0] vel_hold_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_hold_q <= '0;
         vel_hold_q <= '0;
         flags_forced_q <= 1'b1;
      end else if (ce_i && sample_fall) begin
         pos_hold_q <= pos_q[ACC_W-1 -: 12];
         vel_hold_q <= vel_q[ACC_W-1 -: 12];
         flags_forced_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tracking_lost_flag_n_o <= 1'b0;
         degradation_pin_n_o <= 1'b0;
      end else if (ce_i) begin
         tracking_lost_flag_n_o <= ~signal_lost_state & ~lot_raw;
         degradation_pin_n_o <= ~signal_lost_state & ~dos_raw;
      end
   end

   // Serial word
   serial_word_t word;
   logic [SER_W-1:0] shift_q;
   assign word.data = pins.pos_vel_select ? pos_hold_q : vel_hold_q;
   assign word.sel = pins.pos_vel_select;
   assign word.degraded = degradation_pin_n_o;
   assign word.lost = tracking_lost_flag_n_o;
   assign word.parity = ~^{word.data, word.sel, word.degraded, word.lost};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_q <= '0;
      end else if (ce_i) begin
         if (rd_fall) begin
            shift_q <= word;
         end else if (!pins.rd_n && sclk_rise) begin
            // shift on rise, seen on next fall
            shift_q <= {shift_q[SER_W-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_out_o <= 1'b0;
      end else if (ce_i) begin
         serial_out_o <= shift_q[SER_W-1];
      end
   end

   // Encoder emulation and reference pins
   logic [11:0] live_pos;
   assign live_pos = pos_q[ACC_W-1 -: 12];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enc_a_o <= 1'b0;
         enc_b_o <= 1'b0;
         enc_nm_o <= 1'b0;
         enc_dir_o <= 1'b1;
         position_o <= '0;
         excitation_out_o <= 1'b0;
         synth_ref_o <= 1'b0;
      end else if (ce_i) begin
         enc_a_o <= live_pos[1];
         enc_b_o <= live_pos[1] ^ live_pos[0];
         enc_nm_o <= (live_pos[11:2] == 10'h000);
         enc_dir_o <= ~vel_q[ACC_W-1];
         position_o <= live_pos;
         excitation_out_o <= ~exc_phase_q[15];
         synth_ref_o <= synth_ref;
      end
   end

   // Register file
   logic [31:0] rd_data;
   assign rd_data =
      (wb_adr_i == ADR_CTRL) ? {30'h0, ctrl_q} :
      (wb_adr_i == ADR_STATUS) ? {29'h0, signal_lost_state,
                                  degradation_pin_n_o, tracking_lost_flag_n_o} :
      (wb_adr_i == ADR_POS_HOLD) ? {20'h0, pos_hold_q} :
      (wb_adr_i == ADR_VEL_HOLD) ? {20'h0, vel_hold_q} :
      (wb_adr_i == ADR_LIVE) ? {20'h0, live_pos} : 32'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else if (ce_i) begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            wb_dat_o <= rd_data;
         end
         if (wb_wr_ctrl) begin
            ctrl_q <= wb_dat_i[1:0];
         end
      end
   end

endmodule : resolver_tracking_control
`default_nettype wire

//--- verif/resolver_tracking_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module resolver_tracking_control_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Link and outputs
   input wire logic sample_n_i,
   input wire logic rd_n_i,
   input wire logic serial_out_o,
   input wire logic tracking_lost_flag_n_o,
   input wire logic degradation_pin_n_o,
   input wire logic charge_pump_out_o,
   input wire logic enc_a_o,
   input wire logic enc_b_o,
   input wire logic enc_dir_o,
   input wire logic [11:0] position_o
);
   logic seen_q;
   logic [9:0] cp_cnt_q;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Clocks since last charge-pump edge; saturates nowhere, checked below
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seen_q <= 1'b0;
         cp_cnt_q <= 10'h000;
      end else begin
         seen_q <= seen_q | $fell(sample_n_i);
         cp_cnt_q <= $changed(charge_pump_out_o) ? 10'h001 : cp_cnt_q + 10'h001;
      end
   end
   AST_RST_CLEAR: assert property (
      $fell(rst_i) |-> !tracking_lost_flag_n_o && !degradation_pin_n_o && position_o == 12'h000)
      else $error("reset did not clear flags and position");
   AST_RST_ENC: assert property (
      $fell(rst_i) |-> enc_dir_o && !enc_a_o && !enc_b_o && !serial_out_o)
      else $error("reset did not clear encoder and serial outputs");
   AST_FORCED: assert property (
      !seen_q |-> !tracking_lost_flag_n_o && !degradation_pin_n_o)
      else $error("flags released before first sample strobe");
   AST_WB_ACK: assert property (
      ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged next cycle");
   AST_WB_PULSE: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   AST_CP_HALF: assert property (
      $changed(charge_pump_out_o) |-> cp_cnt_q inside {[10'h1DE:10'h1EC]})
      else $error("charge pump half period out of range");
   AST_CP_LIVE: assert property (
      cp_cnt_q <= 10'h1EC)
      else $error("charge pump stopped toggling");
   AST_SER_IDLE: assert property (
      rd_n_i [*8] |=> $stable(serial_out_o))
      else $error("serial output moved while read strobe high");
   COV_SAMPLE: cover property ($fell(sample_n_i) ##[1:20] tracking_lost_flag_n_o);
   COV_READ: cover property ($fell(rd_n_i));
   COV_CP: cover property ($changed(charge_pump_out_o));
endmodule : resolver_tracking_control_monitor
bind resolver_tracking_control resolver_tracking_control_monitor i_mon (.clk_i, .rst_i,
   .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sample_n_i, .rd_n_i, .serial_out_o,
   .tracking_lost_flag_n_o, .degradation_pin_n_o, .charge_pump_out_o, .enc_a_o, .enc_b_o,
   .enc_dir_o, .position_o);
`default_nettype wire

//--- verif/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
   // Clock
   input wire logic clk_i,
   // Link pins
   output logic sclk_o,
   output logic rd_n_o,
   output logic sample_n_o,
   output logic pos_vel_select_o,
   input wire logic serial_i
);
   initial begin
      sclk_o = 1'b1;
      rd_n_o = 1'b1;
      sample_n_o = 1'b1;
      pos_vel_select_o = 1'b1;
   end
   initial begin
      #13;
      forever #80 sclk_o = ~sclk_o;
   end
   task automatic sample_pulse();
      @(posedge clk_i);
      sample_n_o <= 1'b0;
      repeat (10) @(posedge clk_i);
      sample_n_o <= 1'b1;
      repeat (10) @(posedge clk_i);
   endtask : sample_pulse
   // frame sync as read strobe, falls in clock high time
   task automatic read_word(input logic sel, output logic [15:0] w);
      pos_vel_select_o <= sel;
      @(posedge sclk_o);
      #40 rd_n_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(negedge sclk_o);
         w[i] = serial_i;
      end
      #20 rd_n_o = 1'b1;
   endtask : read_word
endmodule : host_link_model
`default_nettype wire

//--- verif/resolver_tracking_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module resolver_tracking_control_tb_top
   import rdc_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
   logic signed [11:0] sin_in_i = 12'h000, cos_in_i = 12'h000;
   logic signed [11:0] sin_amp = 12'h000, cos_amp = 12'h000;
   logic sclk_i, rd_n_i, sample_n_i, pos_vel_select_i, serial_out_o;
   logic tracking_lost_flag_n_o, degradation_pin_n_o, excitation_out_o, synth_ref_o;
   logic charge_pump_out_o, enc_a_o, enc_b_o, enc_nm_o, enc_dir_o;
   logic [11:0] position_o;
   int fail_count = 0;
   int num_checks = 0;
   always #2.5 clk_i = ~clk_i;
   // Resolver model: static angle carried on the excitation, so zero crossings exist
   always @(posedge clk_i) begin
      sin_in_i <= excitation_out_o ? sin_amp : -sin_amp;
      cos_in_i <= excitation_out_o ? cos_amp : -cos_amp;
   end
   resolver_tracking_control i_dut (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hF), .wb_dat_o, .wb_ack_o, .sin_in_i,
      .cos_in_i, .sclk_i, .rd_n_i, .sample_n_i, .pos_vel_select_i, .serial_out_o,
      .tracking_lost_flag_n_o, .degradation_pin_n_o, .excitation_out_o, .synth_ref_o,
      .charge_pump_out_o, .enc_a_o, .enc_b_o, .enc_nm_o, .enc_dir_o, .position_o);
   host_link_model i_host (.clk_i, .sclk_o(sclk_i), .rd_n_o(rd_n_i), .sample_n_o(sample_n_i),
      .pos_vel_select_o(pos_vel_select_i), .serial_i(serial_out_o));
   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check32
   task automatic check_near(input int got, input int exp, input int tol);
      num_checks++;
      if (got > exp + tol || got < exp - tol) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_near
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      // Launch only just after a rising edge, whatever the caller did last
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         print_verdict();
      end
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   // Clocks between excitation edges, bounded
   task automatic half_time(output int n);
      logic v;
      int k;
      k = 0;
      v = excitation_out_o;
      while (excitation_out_o === v && k < 30000) begin
         @(posedge clk_i);
         k++;
      end
      v = excitation_out_o;
      n = 0;
      while (excitation_out_o === v && n < 30000) begin
         @(posedge clk_i);
         n++;
      end
   endtask : half_time
   function automatic int exp_half(input int c);
      int khz[4] = '{20, 15, 12, 10};
      return 100000 / khz[c];
   endfunction : exp_half
   initial begin
      #450000;
      fail_count++;
      print_verdict();
   end
   initial begin
      logic [31:0] r, h;
      logic [15:0] w;
      int n;
      real th;
      void'($urandom(31));
      th = $itor($urandom_range(300, 60)) * 3.14159 / 180.0;
      sin_amp <= 12'($rtoi(1500.0 * $sin(th)));
      cos_amp <= 12'($rtoi(1500.0 * $cos(th)));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check32({20'h0, position_o}, 32'h0);
      check32({tracking_lost_flag_n_o, degradation_pin_n_o}, 32'h0);
      wb(1'b0, ADR_CTRL, 32'h0, r);
      check32(r, 32'h3);
      $display("test reset done");
      // shortened settle; encoder must move before any strobe
      n = 0;
      r[0] = enc_a_o;
      repeat (20000) begin
         @(posedge clk_i);
         if (enc_a_o !== r[0]) n++;
         r[0] = enc_a_o;
      end
      check32(32'(n > 0), 32'h1);
      wb(1'b0, ADR_STATUS, 32'h0, r);
      check32(r & 32'h4, 32'h4);
      $display("test settle done");
      for (int c = 0; c < 4; c++) begin
         wb(1'b1, ADR_CTRL, 32'(c), r);
         wb(1'b0, ADR_CTRL, 32'h0, r);
         check32(r, 32'(c));
         half_time(n);
         check_near(n, exp_half(c), 60);
      end
      wb(1'b1, 8'h20, 32'h0, r);
      wb(1'b0, 8'h20, 32'h0, r);
      check32(r, 32'h0);
      wb(1'b0, ADR_CTRL, 32'h0, r);
      check32(r, 32'h3);
      $display("test excitation done");
      i_host.sample_pulse();
      wb(1'b0, ADR_STATUS, 32'h0, r);
      check32(r & 32'h4, 32'h0);
      for (int i = 0; i < 4; i++) begin
         if (i > 1)
            i_host.sample_pulse();
         i_host.read_word(1'($urandom) ^ 1'(i), w);
         wb(1'b0, w[3] ? ADR_POS_HOLD : ADR_VEL_HOLD, 32'h0, h);
         check32({20'h0, w[15:4]}, h);
         check32({31'h0, ^w}, 32'h1);
         check32({w[2:1]}, {degradation_pin_n_o, tracking_lost_flag_n_o});
         repeat (200) @(posedge clk_i);
         wb(1'b0, w[3] ? ADR_POS_HOLD : ADR_VEL_HOLD, 32'h0, r);
         check32(r, h);
      end
      $display("test serial done");
      print_verdict();
   end
endmodule : resolver_tracking_control_tb_top
`default_nettype wire
